// >>> hdl/fpp_programmer.sv
// Fuse PROM bit programmer: sequences address, selects, pulses and verify
`timescale 1ns/100ps
`include "fpp_map.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module fpp_programmer #(
    parameter int TICK_CYC = `FPP_TICK_CYC
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    prog_sw_i,
    input  wire logic [`FPP_ADDR_W-1:0]  addr_sw_i,
    input  wire logic [`FPP_BITS-1:0]    bit_sw_i,
    input  wire logic [`FPP_BITS-1:0]    prom_out_i,
    output logic                         vcc_on_o,
    output logic                         vcc_low_o,
    output logic [`FPP_ADDR_W-1:0]       prom_addr_o,
    output logic                         cs_n_o,
    output logic                         cs_o,
    output logic [`FPP_BITS-1:0]         programming_pulse_voltage_o,
    output logic [`FPP_BITS-1:0]         led_o,
    output logic [`FPP_BITS-1:0]         fail_o,
    output logic                         busy_o
);
    //////////////////////////////////////////////////////////////////////////
    // Time base and switch conditioning
    fpp_tick_if tk ();
    fpp_tick_gen #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tk         (tk.src)
    );
    fpp_tick_if sw ();
    fpp_debounce u_deb (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .sw_i       (prog_sw_i),
        .tk         (sw.src)
    );

    //////////////////////////////////////////////////////////////////////////
    // Synchronise PROM outputs before any logic reads them
    logic [`FPP_BITS-1:0] po1_q;
    logic [`FPP_BITS-1:0] po2_q;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            po1_q <= '1;
            po2_q <= '1;
        end else begin
            po1_q <= prom_out_i;
            po2_q <= po1_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State and counters
    fpp_pkg::fpp_state_t  st_q;
    fpp_pkg::fpp_state_t  st_d;
    logic [3:0]           pc_q;
    logic [3:0]           pc_d;
    logic [3:0]           bc_q;
    logic [3:0]           bc_d;
    logic [2:0]           np_q;
    logic [2:0]           np_d;
    logic [`FPP_ADDR_W-1:0] addr_q;
    logic [`FPP_BITS-1:0] fail_q;
    logic [`FPP_BITS-1:0] fail_d;

    wire         running  = (st_q == fpp_pkg::FPP_RUN);
    wire         start    = sw.press && (st_q == fpp_pkg::FPP_IDLE);
    wire         step     = running && tk.tick;
    // Pulse counter runs 5,1,2,3,4,5..; slot 5 pulses, slot 3 verifies
    wire [3:0]   pc_next  = (pc_q == `FPP_PULSE_PRESET) ? 4'h1 : pc_q + 4'h1;
    wire         adv      = step && (pc_q == `FPP_ADV_FROM)
                                 && (pc_next == `FPP_ADV_TO);
    wire [2:0]   bit_idx  = 3'(`FPP_BIT_PRESET - bc_q);
    wire         last_bit = (bc_q == 4'h1);
    wire         last_pls = (np_q == `FPP_PULSES_PER_BIT - 3'h1);
    wire         pulse_ph = running && (pc_q == `FPP_PULSE_PRESET);
    // The verify slot sits in the non-pulse phase, after the pulse is gone
    wire         verify   = running && (pc_q == `FPP_ADV_FROM) && !pulse_ph;
    wire [`FPP_BITS-1:0] dec = `FPP_BITS'(1) << bit_idx;
    wire         want     = |(dec & bit_sw_i);
    wire         bit_ok   = !po2_q[bit_idx];
    wire         bit_end  = last_pls || bit_ok || !want;

    // Pulse counter runs only while running; one slot of five is the pulse
    assign pc_d = start ? `FPP_PULSE_PRESET : (step ? pc_next : pc_q);

    // Bit counter and per-bit pulse count
    always_comb begin
        bc_d   = bc_q;
        np_d   = np_q;
        st_d   = st_q;
        fail_d = fail_q;
        if (start) begin
            bc_d   = `FPP_BIT_PRESET;
            np_d   = 3'h0;
            fail_d = '0;
            st_d   = fpp_pkg::FPP_RUN;
        end else if (adv) begin
            if (bit_end) begin
                if (want && !bit_ok) begin
                    fail_d[bit_idx] = 1'b1;
                end
                np_d = 3'h0;
                if (last_bit) begin
                    bc_d = `FPP_BIT_PRESET;
                    st_d = fpp_pkg::FPP_DONE;
                end else begin
                    bc_d = bc_q - 4'h1;
                end
            end else begin
                np_d = np_q + 3'h1;
            end
        end else if (st_q == fpp_pkg::FPP_DONE) begin
            st_d = fpp_pkg::FPP_IDLE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q   <= fpp_pkg::FPP_IDLE;
            pc_q   <= `FPP_PULSE_PRESET;
            bc_q   <= `FPP_BIT_PRESET;
            np_q   <= 3'h0;
            fail_q <= '0;
        end else begin
            st_q   <= st_d;
            pc_q   <= pc_d;
            bc_q   <= bc_d;
            np_q   <= np_d;
            fail_q <= fail_d;
        end
    end

    // Address latched at start and held for the whole word
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            addr_q <= '0;
        end else if (!running) begin
            addr_q <= addr_sw_i;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin drive, all registered
    wire [`FPP_BITS-1:0] pulse_d = (pulse_ph && want && !bit_ok && !adv)
                                   ? dec : '0;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            vcc_on_o                    <= 1'b0;
            vcc_low_o                   <= 1'b0;
            prom_addr_o                 <= '0;
            cs_n_o                      <= 1'b1;
            cs_o                        <= 1'b0;
            programming_pulse_voltage_o <= '0;
            led_o                       <= '0;
            fail_o                      <= '0;
            busy_o                      <= 1'b0;
        end else begin
            vcc_on_o                    <= 1'b1;
            vcc_low_o                   <= verify;
            prom_addr_o                 <= running ? addr_q : addr_sw_i;
            cs_n_o                      <= running && !verify;
            cs_o                        <= !(running && !verify);
            programming_pulse_voltage_o <= vcc_on_o ? pulse_d : '0;
            led_o                       <= running ? '0 : po2_q;
            fail_o                      <= fail_q;
            busy_o                      <= running;
        end
    end
endmodule // fpp_programmer

// >>> inc/fpp_map.svh
// Constants for the fuse PROM bit programmer: timing, presets and widths
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH

`define FPP_CLK_HZ          100000000
`define FPP_TICK_HZ         10000
`define FPP_TICK_CYC        (`FPP_CLK_HZ / `FPP_TICK_HZ)
`define FPP_DEB_CYC         1000
`define FPP_PULSE_PRESET    4'h5
`define FPP_PULSE_ON_STATE  4'h0
`define FPP_ADV_FROM        4'h3
`define FPP_ADV_TO          4'h4
`define FPP_BIT_PRESET      4'h8
`define FPP_BITS            8
`define FPP_ADDR_W          10
`define FPP_PULSES_PER_BIT  3'h4

`endif

// >>> inc/fpp_pkg.sv
// Types for the fuse PROM bit programmer
package fpp_pkg;
    typedef enum logic [1:0] {
        FPP_IDLE,
        FPP_RUN,
        FPP_DONE
    } fpp_state_t;
endpackage

// >>> inc/fpp_tick_if.sv
// Interface carrying the time base and debounced switch between modules
`timescale 1ns/100ps
interface fpp_tick_if;
    logic tick;
    logic press;
    modport src (output tick, output press);
    modport dst (input tick, input press);
endinterface

// >>> hdl/fpp_tick_gen.sv
// 10 kHz time base derived from the core clock
`timescale 1ns/100ps
`include "fpp_map.svh"
module fpp_tick_gen #(
    parameter int TICK_CYC = `FPP_TICK_CYC
) (
    input  wire logic   core_clk_i,
    input  wire logic   rst_i,
    fpp_tick_if.src     tk
);
    logic [13:0] cnt_q;
    logic [13:0] cnt_d;
    logic        tick_q;
    wire         wrap = (cnt_q == 14'(TICK_CYC - 1));

    // Free-running divider, one pulse per period
    assign cnt_d = wrap ? 14'h0000 : cnt_q + 14'h0001;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_q  <= 14'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= wrap;
        end
    end
    assign tk.tick = tick_q;
endmodule // fpp_tick_gen

// >>> hdl/fpp_debounce.sv
// Switch synchroniser, debouncer and press edge detector
`timescale 1ns/100ps
`include "fpp_map.svh"
module fpp_debounce (
    input  wire logic   core_clk_i,
    input  wire logic   rst_i,
    input  wire logic   sw_i,
    fpp_tick_if.src     tk
);
    logic        s1_q, s2_q, st_q, press_q;
    logic [9:0]  cnt_q;
    wire         same = (s2_q == st_q);
    wire         done = (cnt_q == 10'(`FPP_DEB_CYC - 1));

    // Two-stage sync, then accept a level stable for the hold time
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            st_q    <= 1'b0;
            cnt_q   <= 10'h000;
            press_q <= 1'b0;
        end else begin
            s1_q    <= sw_i;
            s2_q    <= s1_q;
            press_q <= 1'b0;
            if (same) begin
                cnt_q <= 10'h000;
            end else if (done) begin
                st_q    <= s2_q;
                press_q <= s2_q;
                cnt_q   <= 10'h000;
            end else begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end
    assign tk.press = press_q;
endmodule // fpp_debounce

// >>> test/fpp_programmer_sva.sv
// Assertion checker for the fuse PROM bit programmer
`timescale 1ns/100ps
`include "fpp_map.svh"
module fpp_programmer_sva (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    input  wire logic [`FPP_BITS-1:0]   bit_sw_i,
    input  wire logic                   vcc_on_o,
    input  wire logic                   vcc_low_o,
    input  wire logic [`FPP_ADDR_W-1:0] prom_addr_o,
    input  wire logic                   cs_n_o,
    input  wire logic                   cs_o,
    input  wire logic [`FPP_BITS-1:0]   programming_pulse_voltage_o,
    input  wire logic                   busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] hi_q;
    wire         pon = |programming_pulse_voltage_o;
    // Cycles the current pulse has stood
    always_ff @(posedge core_clk_i) begin
        hi_q <= (rst_i || !pon) ? 16'h0 : hi_q + 16'h1;
    end
    property p_one; $onehot0(programming_pulse_voltage_o); endproperty
    a_one: assert property (p_one) else $error("two outputs pulsed");
    property p_desel; pon |-> cs_n_o && !cs_o; endproperty
    a_desel: assert property (p_desel) else $error("selected in pulse");
    property p_pwr; (pon || vcc_low_o) |-> vcc_on_o; endproperty
    a_pwr: assert property (p_pwr) else $error("no supply");
    property p_addr; busy_o && $past(busy_o) |-> $stable(prom_addr_o); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_verify; vcc_low_o |-> !cs_n_o && cs_o && !pon; endproperty
    a_verify: assert property (p_verify) else $error("bad verify");
    property p_sel; pon |-> (programming_pulse_voltage_o & ~bit_sw_i) == 8'h00; endproperty
    a_sel: assert property (p_sel) else $error("unselected bit pulsed");
    property p_run; pon |-> busy_o; endproperty
    a_run: assert property (p_run) else $error("pulse while idle");
    property p_duty; hi_q <= 16'h2710; endproperty
    a_duty: assert property (p_duty) else $error("pulse too long");
    c_pulse: cover property (pon);
    c_verify: cover property (vcc_low_o);
    c_done: cover property ($fell(busy_o));
endmodule // fpp_programmer_sva

bind fpp_programmer fpp_programmer_sva u_sva (.core_clk_i, .rst_i, .bit_sw_i, .vcc_on_o,
    .vcc_low_o, .prom_addr_o, .cs_n_o, .cs_o, .programming_pulse_voltage_o, .busy_o);

// >>> test/fpp_prom_model.sv
// Behavioural fuse PROM seen from the programmer's pins
`timescale 1ns/100ps
`include "fpp_map.svh"
module fpp_prom_model (
    input  wire logic                   vcc_on_i,
    input  wire logic [`FPP_ADDR_W-1:0] addr_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   cs_i,
    input  wire logic [`FPP_BITS-1:0]   pulse_i,
    output logic      [`FPP_BITS-1:0]   dout_o
);
    logic [`FPP_BITS-1:0] mem [0:1023];
    wire                  sel = vcc_on_i && !cs_n_i && cs_i;
    // Blank part reads all ones
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'hff;
    end
    // A lone pulse while deselected opens that fuse; nothing restores it
    always @(pulse_i or cs_n_i or cs_i or vcc_on_i or addr_i) begin
        if (vcc_on_i && cs_n_i && !cs_i && $onehot(pulse_i)) begin
            mem[addr_i] = mem[addr_i] & ~pulse_i;
        end
    end
    // Unselected open-collector outputs rise to the pull-up level
    assign dout_o = sel ? mem[addr_i] : 8'hff;
endmodule // fpp_prom_model

// >>> test/tb_top.sv
// Testbench for the fuse PROM bit programmer
`timescale 1ns/100ps
`include "fpp_map.svh"
module tb_top;
    logic                   core_clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic                   prog_sw_i = 1'b0;
    logic [`FPP_ADDR_W-1:0] addr_sw_i = 10'h000;
    logic [`FPP_BITS-1:0]   bit_sw_i = 8'h00;
    logic [`FPP_BITS-1:0]   dout, pulse, led, fail;
    logic [`FPP_ADDR_W-1:0] addr;
    logic                   von, vlow, csn, cs, busy;
    int                     error_cnt = 0;
    int                     num_checks = 0;
    int                     seed = 32'h24995f2d;
    int                     exp_word;
    always #5 core_clk_i = ~core_clk_i;
    // Short time base keeps a whole word within the run budget
    fpp_programmer #(.TICK_CYC(100)) DUT (.core_clk_i, .rst_i, .prog_sw_i, .addr_sw_i, .bit_sw_i,
        .prom_out_i(dout), .vcc_on_o(von), .vcc_low_o(vlow), .prom_addr_o(addr),
        .cs_n_o(csn), .cs_o(cs), .programming_pulse_voltage_o(pulse), .led_o(led),
        .fail_o(fail), .busy_o(busy));
    fpp_prom_model P (.vcc_on_i(von), .addr_i(addr), .cs_n_i(csn), .cs_i(cs),
        .pulse_i(pulse), .dout_o(dout));
    ////////////////////////////////////////////////////////////////////////////
    // Compare, wait and finish helpers
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic press();
        prog_sw_i <= 1'b1;
        repeat (1100) @(posedge core_clk_i);
        prog_sw_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: one word with one random bit, a second press mid-run
    initial begin
        int a;
        int n;
        a = $random(seed);
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        addr_sw_i <= a[9:0];
        bit_sw_i <= 8'h01 << a[12:10];
        exp_word = 8'hff & ~(1 << a[12:10]);
        repeat (20) @(posedge core_clk_i);
        chk("idle led", led, 8'hff);
        press();
        @(posedge core_clk_i);
        chk("busy", {7'h00, busy}, 8'h01);
        // Let the release settle so the second press is a real new press
        repeat (1100) @(posedge core_clk_i);
        press();
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge core_clk_i);
            n++;
        end
        chk("finished", {7'h00, busy}, 8'h00);
        repeat (20) @(posedge core_clk_i);
        chk("word", P.mem[a[9:0]], exp_word[7:0]);
        chk("neighbour", P.mem[a[9:0] ^ 10'h001], 8'hff);
        chk("fail", fail, 8'h00);
        chk("led", led, exp_word[7:0]);
        repeat (2000) @(posedge core_clk_i);
        chk("no rerun", {7'h00, busy}, 8'h00);
        conclude();
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge core_clk_i);
        error_cnt++;
        conclude();
    end
endmodule // tb_top
